// [include/smbrg_pkg.sv]
// Package with register map, command codes and state encoding of the sleep mask register bank.
`default_nettype none
package smbrg_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_TREE_TEST   = 8'h00;
  localparam logic [7:0] ADDR_SLEEP       = 8'hE4;
  localparam logic [7:0] ADDR_S1_INPUT    = 8'hE5;
  localparam logic [7:0] ADDR_S1_TACH     = 8'hE6;
  localparam logic [7:0] ADDR_S3_INPUT    = 8'hE7;
  localparam logic [7:0] ADDR_S3_TACH     = 8'hE8;
  localparam logic [7:0] ADDR_S3_TV       = 8'hE9;
  localparam logic [7:0] ADDR_S45_INPUT   = 8'hEA;
  localparam logic [7:0] ADDR_S45_TV      = 8'hEB;
  localparam logic [7:0] ADDR_INPUT_FAULT = 8'hEC;
  localparam logic [7:0] ADDR_MISC_FAULT  = 8'hED;
  localparam logic [7:0] ADDR_Z1A_OFFSET  = 8'hEE;
  localparam logic [7:0] ADDR_Z2A_OFFSET  = 8'hEF;
  // Reset values.
  localparam logic [7:0] RST_TREE_TEST    = 8'h00;
  localparam logic [7:0] RST_SLEEP        = 8'h03;
  localparam logic [7:0] RST_INPUT_MASK   = 8'hFF;
  localparam logic [7:0] RST_TACH_MASK    = 8'h0F;
  localparam logic [7:0] RST_TV_MASK      = 8'h07;
  localparam logic [7:0] RST_MISC_MASK    = 8'h3F;
  localparam logic [7:0] RST_OFFSET       = 8'h00;
  // Field positions.
  localparam int         TREE_TEST_BIT    = 0;
  localparam int         SLEEP_CODE_MSB   = 2;
  // Sleep state codes held in the low bits of the sleep register.
  localparam logic [2:0] SLEEP_S1         = 3'h1;
  localparam logic [2:0] SLEEP_S3         = 3'h3;
  localparam logic [2:0] SLEEP_S4         = 3'h4;
  localparam logic [2:0] SLEEP_S5         = 3'h5;
  // Command codes.
  localparam logic [7:0] CMD_BLOCK_WRITE  = 8'hF0;
  localparam logic [7:0] CMD_PROC_CALL    = 8'hF1;
  localparam logic [7:0] CMD_FIXED_FIRST  = 8'hF2;
  localparam logic [7:0] CMD_FIXED_LAST   = 8'hFD;
  // Fixed block start addresses and lengths, indexed by command minus the first fixed code.
  localparam logic [7:0] FIXED_BASE [12]  = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6E,
                                              8'h78, 8'h90, 8'hB4, 8'hC8, 8'hD0, 8'hE5};
  localparam logic [7:0] FIXED_LEN  [12]  = '{8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08,
                                              8'h0C, 8'h20, 8'h08, 8'h08, 8'h10, 8'h09};
  // Byte engine states, Gray coded along the write path.
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hC
  } smbrg_state_t;
endpackage : smbrg_pkg
`default_nettype wire

// [include/smbrg_reg_if.sv]
// Interface between the serial engine and the register store.
`default_nettype none
interface smbrg_reg_if;
  logic       wr_en;        // One-cycle write strobe.
  logic [7:0] wr_addr;      // Write register address.
  logic [7:0] wr_data;      // Write data.
  logic [7:0] rd_addr;      // Read register address.
  logic [7:0] rd_data;      // Registered read data.
  logic [7:0] tree_test;    // Factory test register.
  logic [7:0] sleep;        // Sleep state register.
  logic [7:0] masks [11];   // Mask and offset registers E5h to EFh in order.
  modport engine (output wr_en, wr_addr, wr_data, rd_addr, input rd_data, tree_test, sleep, masks);
  modport store  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data, tree_test, sleep, masks);
endinterface : smbrg_reg_if
`default_nettype wire

// [verilog/smbrg_regfile.sv]
// Register store with registered read data.
`default_nettype none
module smbrg_regfile
  import smbrg_pkg::*;
(
  input  wire logic  i_clk,    // System clock.
  input  wire logic  i_reset,  // Synchronous reset, active high.
  smbrg_reg_if.store bus       // Engine side access.
);
  logic [7:0] idx;  // Offset of an access from the sleep register.

  // Index of a write into the mask and offset group.
  assign idx = bus.wr_addr - ADDR_SLEEP;

  // Writes; only mapped addresses store, so command codes never touch state.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.tree_test <= RST_TREE_TEST;
      bus.sleep     <= RST_SLEEP;
      bus.masks     <= '{RST_INPUT_MASK, RST_TACH_MASK, RST_INPUT_MASK, RST_TACH_MASK, RST_TV_MASK,
                         RST_INPUT_MASK, RST_TV_MASK, RST_INPUT_MASK, RST_MISC_MASK, RST_OFFSET, RST_OFFSET};
    end else if (bus.wr_en) begin
      if (bus.wr_addr == ADDR_TREE_TEST) begin
        bus.tree_test <= {7'h00, bus.wr_data[TREE_TEST_BIT]};
      end
      if (bus.wr_addr == ADDR_SLEEP) begin
        bus.sleep <= bus.wr_data;
      end
      if (bus.wr_addr >= ADDR_S1_INPUT && bus.wr_addr <= ADDR_Z2A_OFFSET) begin
        bus.masks[idx[3:0] - 4'h1] <= bus.wr_data;
      end
    end
  end

  // Read port; unmapped addresses read as zero.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.rd_data <= 8'h00;
    end else if (bus.rd_addr == ADDR_TREE_TEST) begin
      bus.rd_data <= bus.tree_test;
    end else if (bus.rd_addr == ADDR_SLEEP) begin
      bus.rd_data <= bus.sleep;
    end else if (bus.rd_addr >= ADDR_S1_INPUT && bus.rd_addr <= ADDR_Z2A_OFFSET) begin
      bus.rd_data <= bus.masks[4'(bus.rd_addr - ADDR_SLEEP) - 4'h1];
    end else begin
      bus.rd_data <= 8'h00;
    end
  end
endmodule : smbrg_regfile
`default_nettype wire

// [verilog/smbrg_top.sv]
// Two-wire register slave with sleep masks, error gating, temperature offsets and block commands.
//
// What this block does
// - Test register bit 0 enables tree test
// - F0h decodes as block write to registers
// - F1h decodes as write then read call
// - F2h block reads 8 bytes from 40h
// - F3h block reads 8 bytes from 48h
// - F4h block reads 6 bytes from 50h
// - F5h block reads 16 bytes from 56h
// - F6h block reads 4 bytes from 67h
// - F7h block reads 8 bytes from 6Eh
// - F8h block reads 12 bytes from 78h
// - F9h block reads 32 bytes from 90h
// - FAh block reads 8 bytes from B4h
// - FBh block reads 8 bytes from C8h
// - FCh block reads 16 bytes from D0h
// - FDh block reads 9 bytes from E5h
// - FEh and FFh have no function
// - Host writes sleep state at E4h
// - S1 masks inputs and tach errors
// - S3 masks inputs, tach, temperature, voltage
// - S4/S5 mask inputs, temperature and voltage
// - Always-on input and miscellaneous fault masks
// - Zone offsets added to zone temperatures
`default_nettype none
module smbrg_top
  import smbrg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2C  // Slave address on the two-wire bus.
) (
  input  wire logic       i_clk,                // System clock, 50 MHz.
  input  wire logic       i_reset,              // Synchronous reset, active high.
  input  wire logic       i_scl,                // Serial clock level.
  input  wire logic       i_sda,                // Serial data level.
  output logic            o_sda_out,            // Serial data drive value, always low.
  output logic            o_sda_oe,             // Serial data drive enable.
  input  wire logic [7:0] i_general_input_err,  // Raw general input errors.
  input  wire logic [3:0] i_tach_err,           // Raw fan tachometer errors.
  input  wire logic [2:0] i_temp_volt_err,      // Raw temperature or voltage errors.
  input  wire logic [5:0] i_misc_err,           // Raw regulator hot, input and core supply errors.
  input  wire logic [7:0] i_zone1a_temp,        // Zone 1a raw temperature.
  input  wire logic [7:0] i_zone2a_temp,        // Zone 2a raw temperature.
  output logic      [7:0] o_general_input_err,  // Reported general input errors.
  output logic      [3:0] o_tach_err,           // Reported tachometer errors.
  output logic      [2:0] o_temp_volt_err,      // Reported temperature or voltage errors.
  output logic      [5:0] o_misc_err,           // Reported miscellaneous errors.
  output logic      [7:0] o_zone1a_adj,         // Zone 1a adjusted temperature.
  output logic      [7:0] o_zone2a_adj,         // Zone 2a adjusted temperature.
  output logic            o_tree_test_enable    // Tree test mode active.
);
  import smbrg_pkg::*;

  smbrg_reg_if  regs ();      // Link to the register store.
  smbrg_state_t state;        // Byte engine state.
  logic         scl_q;        // Clock level one cycle ago.
  logic         sda_q;        // Data level one cycle ago.
  logic         scl_rise;     // Clock rising edge.
  logic         scl_fall;     // Clock falling edge.
  logic         bus_start;    // Start or repeated start seen.
  logic         bus_stop;     // Stop seen.
  logic [7:0]   shift_in;     // Received bits.
  logic [7:0]   shift_out;    // Bits still to send.
  logic [3:0]   bit_cnt;      // Bits handled in this byte.
  logic         is_read;      // Current transfer reads.
  logic [7:0]   cmd;          // Latched command code.
  logic [7:0]   ptr;          // Register pointer.
  logic [5:0]   wr_idx;       // Data bytes received since the command.
  logic [7:0]   read_len;     // Length returned by the process call.
  logic         len_phase;    // Next read byte is the block length.
  logic [7:0]   next_tx;      // Byte to load for sending.
  logic [16:0]  fixed;        // Fixed block decode of the command.
  logic [16:0]  fixed_new;    // Fixed block decode of the byte just received.
  logic         wr_en;        // Store write strobe.
  logic [7:0]   wr_addr;      // Store write address.
  logic [7:0]   wr_data;      // Store write data.

  // Decode a command into {is fixed block, start address, length}.
  function automatic logic [16:0] fixed_block(input logic [7:0] code);
    logic [3:0] n;
    n = 4'(code - CMD_FIXED_FIRST);
    if (code >= CMD_FIXED_FIRST && code <= CMD_FIXED_LAST) begin
      fixed_block = {1'b1, FIXED_BASE[n], FIXED_LEN[n]};
    end else begin
      fixed_block = 17'h00000;
    end
  endfunction : fixed_block

  // Register store; read data come one cycle after the pointer moves.
  smbrg_regfile u_regfile (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .bus     (regs.store)
  );

  assign regs.wr_en   = wr_en;
  assign regs.wr_addr = wr_addr;
  assign regs.wr_data = wr_data;
  assign regs.rd_addr = ptr;

  // Bus conditions; pins are synchronous so the previous sample is enough.
  assign scl_rise  = i_scl & ~scl_q;
  assign scl_fall  = ~i_scl & scl_q;
  assign bus_start = i_scl & scl_q & sda_q & ~i_sda;
  assign bus_stop  = i_scl & scl_q & ~sda_q & i_sda;

  // Fixed block lookup for the latched command and for the byte just received.
  assign fixed = fixed_block(cmd);
  assign fixed_new = fixed_block(shift_in);

  // Next byte to send: a block length first, otherwise the register at the pointer.
  always_comb begin
    if (len_phase && cmd == CMD_PROC_CALL) begin
      next_tx = read_len;
    end else if (len_phase) begin
      next_tx = fixed[7:0];
    end else begin
      next_tx = regs.rd_data;
    end
  end

  // Previous pin levels for edge detection.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Byte engine: framing, acknowledge and data drive.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state     <= ST_IDLE;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt   <= 4'h0;
      is_read   <= 1'b0;
    end else if (bus_start) begin
      // A repeated start keeps the command and pointer for the read half.
      state    <= ST_ADDR;
      bit_cnt  <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state    <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_in <= {shift_in[6:0], i_sda};
            bit_cnt  <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR && shift_in[7:1] != DEV_ADDR) begin
              // Another slave is addressed; stay off the bus until the next start.
              state <= ST_IDLE;
            end else begin
              o_sda_oe <= 1'b1;
              is_read  <= (state == ST_ADDR) ? shift_in[0] : is_read;
              state    <= (state == ST_ADDR) ? ST_ADDR_ACK :
                          (state == ST_CMD) ? ST_CMD_ACK : ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (scl_rise && state == ST_RDATA_ACK && i_sda) begin
            // The host declined more data; wait for its stop.
            state <= ST_IDLE;
          end else if (scl_fall && (is_read || state == ST_RDATA_ACK)) begin
            o_sda_oe  <= ~next_tx[7];
            shift_out <= {next_tx[6:0], 1'b0};
            bit_cnt   <= 4'h1;
            state     <= ST_RDATA;
          end else if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state    <= ST_CMD;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state    <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall && bit_cnt == 4'h8) begin
            // Release the line for the host's acknowledge.
            o_sda_oe <= 1'b0;
            state    <= ST_RDATA_ACK;
          end else if (scl_fall) begin
            o_sda_oe  <= ~shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            bit_cnt   <= bit_cnt + 4'h1;
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Command decode, pointer movement and store writes.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cmd       <= 8'h00;
      ptr       <= 8'h00;
      wr_idx    <= 6'h00;
      read_len  <= 8'h00;
      len_phase <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (state == ST_CMD && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop) begin
        cmd    <= shift_in;
        wr_idx <= 6'h00;
        ptr    <= fixed_new[16] ? fixed_new[15:8] : shift_in;
      end else if (state == ST_WDATA && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop) begin
        wr_idx  <= (wr_idx == 6'h3F) ? wr_idx : wr_idx + 6'h01;
        wr_data <= shift_in;
        wr_addr <= ptr;
        if (cmd < CMD_BLOCK_WRITE) begin
          // Plain register write with pointer advance.
          wr_en <= 1'b1;
          ptr   <= ptr + 8'h01;
        end else if (cmd == CMD_BLOCK_WRITE || cmd == CMD_PROC_CALL) begin
          if (wr_idx == 6'h01) begin
            ptr <= shift_in;
          end else if (wr_idx == 6'h02 && cmd == CMD_PROC_CALL) begin
            read_len <= shift_in;
          end else if (wr_idx >= 6'h02) begin
            wr_en <= 1'b1;
            ptr   <= ptr + 8'h01;
          end
        end
      end else if (state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop) begin
        len_phase <= shift_in[0] && (fixed[16] || cmd == CMD_PROC_CALL);
      end else if (state == ST_RDATA && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop) begin
        // The length byte does not consume a register.
        if (len_phase) begin
          len_phase <= 1'b0;
        end else begin
          ptr <= ptr + 8'h01;
        end
      end
    end
  end

  // Sleep-state error gating; a set mask bit suppresses the error.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_general_input_err <= 8'h00;
      o_tach_err          <= 4'h0;
      o_temp_volt_err     <= 3'h0;
    end else begin
      case (regs.sleep[SLEEP_CODE_MSB:0])
        SLEEP_S1: begin
          o_general_input_err <= i_general_input_err & ~regs.masks[0] & ~regs.masks[7];
          o_tach_err          <= i_tach_err & ~regs.masks[1][3:0];
          o_temp_volt_err     <= i_temp_volt_err;
        end
        SLEEP_S3: begin
          o_general_input_err <= i_general_input_err & ~regs.masks[2] & ~regs.masks[7];
          o_tach_err          <= i_tach_err & ~regs.masks[3][3:0];
          o_temp_volt_err     <= i_temp_volt_err & ~regs.masks[4][2:0];
        end
        SLEEP_S4, SLEEP_S5: begin
          o_general_input_err <= i_general_input_err & ~regs.masks[5] & ~regs.masks[7];
          o_tach_err          <= i_tach_err;
          o_temp_volt_err     <= i_temp_volt_err & ~regs.masks[6][2:0];
        end
        default: begin
          o_general_input_err <= i_general_input_err & ~regs.masks[7];
          o_tach_err          <= i_tach_err;
          o_temp_volt_err     <= i_temp_volt_err;
        end
      endcase
    end
  end

  // Miscellaneous error gating, independent of sleep state.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_misc_err <= 6'h00;
    end else begin
      o_misc_err <= i_misc_err & ~regs.masks[8][5:0];
    end
  end

  // Temperature offsets, two's complement, wrapping at eight bits.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_zone1a_adj <= 8'h00;
      o_zone2a_adj <= 8'h00;
    end else begin
      o_zone1a_adj <= i_zone1a_temp + regs.masks[9];
      o_zone2a_adj <= i_zone2a_temp + regs.masks[10];
    end
  end

  // Test mode output follows the stored enable bit.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_tree_test_enable <= 1'b0;
    end else begin
      o_tree_test_enable <= regs.tree_test[TREE_TEST_BIT];
    end
  end
endmodule : smbrg_top
`default_nettype wire

// [verif/smbrg_properties.sv]
// Port-level checker for the sleep mask register slave, bound to its top module.
`default_nettype none
module smbrg_properties (
  input wire logic       i_clk,               // Clock.
  input wire logic       i_reset,             // Reset.
  input wire logic       i_scl,               // Serial clock.
  input wire logic       i_sda,               // Serial data.
  input wire logic       o_sda_out,           // Data drive.
  input wire logic       o_sda_oe,            // Drive enable.
  input wire logic [7:0] i_general_input_err, // Raw input errors.
  input wire logic [3:0] i_tach_err,          // Raw tach errors.
  input wire logic [2:0] i_temp_volt_err,     // Raw temp errors.
  input wire logic [5:0] i_misc_err,          // Raw misc errors.
  input wire logic [7:0] i_zone1a_temp,       // Zone 1a raw.
  input wire logic [7:0] i_zone2a_temp,       // Zone 2a raw.
  input wire logic [7:0] o_general_input_err, // Gated input errors.
  input wire logic [3:0] o_tach_err,          // Gated tach errors.
  input wire logic [2:0] o_temp_volt_err,     // Gated temp errors.
  input wire logic [5:0] o_misc_err,          // Gated misc errors.
  input wire logic [7:0] o_zone1a_adj,        // Zone 1a adjusted.
  input wire logic [7:0] o_zone2a_adj,        // Zone 2a adjusted.
  input wire logic       o_tree_test_enable   // Test mode.
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Clock held high for three samples out of reset, so no register write can be in flight.
  sequence s_bus_idle;
    (i_scl && !i_reset) [*3];
  endsequence
  chk_reset_quiet: assert property ($past(i_reset) |-> !o_sda_oe && !o_tree_test_enable && o_misc_err == 6'h00)
    else $error("outputs not quiet after reset");
  chk_drive_low: assert property (o_sda_oe |-> o_sda_out == 1'b0)
    else $error("data driven high");
  chk_oe_clock_low: assert property (!$stable(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data drive changed with clock high");
  chk_tree_on_write: assert property (!$stable(o_tree_test_enable) |-> !i_scl && !$past(i_scl))
    else $error("test mode changed outside a write");
  chk_input_gate: assert property (o_general_input_err == (o_general_input_err & $past(i_general_input_err)))
    else $error("input error reported without cause");
  chk_tach_gate: assert property (o_tach_err == (o_tach_err & $past(i_tach_err)))
    else $error("tach error reported without cause");
  chk_tv_gate: assert property (o_temp_volt_err == (o_temp_volt_err & $past(i_temp_volt_err)))
    else $error("temp error reported without cause");
  chk_misc_gate: assert property (o_misc_err == (o_misc_err & $past(i_misc_err)))
    else $error("misc error reported without cause");
  chk_zone1_track: assert property (s_bus_idle |->
    8'(o_zone1a_adj - $past(o_zone1a_adj)) == 8'($past(i_zone1a_temp) - $past(i_zone1a_temp, 2)))
    else $error("zone 1a offset drifts");
  chk_zone2_track: assert property (s_bus_idle |->
    8'(o_zone2a_adj - $past(o_zone2a_adj)) == 8'($past(i_zone2a_temp) - $past(i_zone2a_temp, 2)))
    else $error("zone 2a offset drifts");
endmodule : smbrg_properties
bind smbrg_top smbrg_properties chk_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .i_general_input_err(i_general_input_err), .i_tach_err(i_tach_err), .i_temp_volt_err(i_temp_volt_err),
  .i_misc_err(i_misc_err), .i_zone1a_temp(i_zone1a_temp), .i_zone2a_temp(i_zone2a_temp),
  .o_general_input_err(o_general_input_err), .o_tach_err(o_tach_err), .o_temp_volt_err(o_temp_volt_err),
  .o_misc_err(o_misc_err), .o_zone1a_adj(o_zone1a_adj), .o_zone2a_adj(o_zone2a_adj),
  .o_tree_test_enable(o_tree_test_enable)
);
`default_nettype wire

// [verif/smbrg_host.sv]
// Two-wire host model that drives the serial clock and data toward the register slave.
`default_nettype none
module smbrg_host (
  input  wire logic i_clk, // System clock.
  input  wire logic i_sda, // Resolved data line.
  output var  logic o_scl, // Serial clock drive.
  output var  logic o_sda  // Data drive, one releases to the pull-up.
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 6; // Clocks per half period, well above the three-clock minimum.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Waits whole clocks and steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond;
    o_sda = 1'b1;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda = 1'b0;
    tick(HALF);
    o_scl = 1'b0;
    tick(1);
  endtask : start_cond
  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop_cond;
    o_sda = 1'b0;
    tick(HALF);
    o_scl = 1'b1;
    tick(HALF);
    o_sda = 1'b1;
    tick(HALF);
  endtask : stop_cond
  // Nine bit slots, MSB first; data is held one clock past each fall for hold time.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_sda = tx[i];
      tick(HALF);
      o_scl = 1'b1;
      tick(HALF);
      rx[i] = i_sda;
      o_scl = 1'b0;
      tick(1);
    end
  endtask : xfer
endmodule : smbrg_host
`default_nettype wire

// [verif/smbrg_top_tb.sv]
// Self-checking testbench for the sleep mask register slave.
`default_nettype none
module smbrg_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = 7'h2C; // Slave address the bench uses.
  localparam logic [7:0] RSTV [12] = '{8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h07, 8'hFF, 8'h07,
    8'hFF, 8'h3F, 8'h00, 8'h00};
  localparam logic [7:0] LENS [11] = '{8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h08, 8'h08, 8'h10};
  localparam logic [7:0] MSK [9] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h04, 8'h04, 8'h80, 8'h05};
  localparam logic [7:0] SL [5] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h00};
  localparam logic [7:0] EG [5] = '{8'h7E, 8'h7D, 8'h7B, 8'h7B, 8'h7F};
  localparam logic [7:0] ET [5] = '{8'h0E, 8'h0D, 8'h0F, 8'h0F, 8'h0F};
  localparam logic [7:0] EV [5] = '{8'h07, 8'h05, 8'h03, 8'h03, 8'h07};
  logic       clk, rst;                    // Clock and reset.
  logic [7:0] gi_in, z1, z2;               // Raw inputs.
  logic [3:0] ta_in;                       // Raw tach errors.
  logic [2:0] tv_in;                       // Raw temp errors.
  logic [5:0] mi_in;                       // Raw misc errors.
  wire  logic scl, sda_h, sda_w, sda_out, sda_oe, tte;
  wire  logic [7:0] gi_o, z1_o, z2_o;      // Gated and adjusted outputs.
  wire  logic [3:0] ta_o;
  wire  logic [2:0] tv_o;
  wire  logic [5:0] mi_o;
  logic [7:0] rb [16];                     // Bytes of the last read.
  int         error_cnt, n_checks;
  // The slave pulls low when enabled; otherwise the host value stands, one meaning pulled up.
  assign sda_w = sda_oe ? sda_out : sda_h;
  smbrg_top dut_u (
    .i_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_general_input_err(gi_in), .i_tach_err(ta_in), .i_temp_volt_err(tv_in), .i_misc_err(mi_in),
    .i_zone1a_temp(z1), .i_zone2a_temp(z2), .o_general_input_err(gi_o), .o_tach_err(ta_o),
    .o_temp_volt_err(tv_o), .o_misc_err(mi_o), .o_zone1a_adj(z1_o), .o_zone2a_adj(z2_o),
    .o_tree_test_enable(tte)
  );
  smbrg_host host_u (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Prints the verdict and ends the run.
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Sends one byte; the slave must acknowledge by pulling data low.
  task automatic put(input logic [7:0] d);
    logic [8:0] rx;
    host_u.xfer({d, 1'b1}, rx);
    check("ack", {7'h00, rx[0]}, 8'h00);
  endtask : put
  // Write transfer: address, then the given bytes, then stop.
  task automatic wr(input logic [7:0] q [$]);
    host_u.start_cond();
    put({DEV, 1'b0});
    foreach (q[i]) put(q[i]);
    host_u.stop_cond();
  endtask : wr
  // Write prefix, repeated start, n reads; the last byte is not acknowledged.
  task automatic rd(input logic [7:0] q [$], input int n);
    logic [8:0] rx;
    host_u.start_cond();
    put({DEV, 1'b0});
    foreach (q[i]) put(q[i]);
    host_u.start_cond();
    put({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      host_u.xfer({8'hFF, i == n - 1}, rx);
      rb[i] = rx[8:1];
    end
    host_u.stop_cond();
  endtask : rd
  initial begin
    error_cnt = 0;
    n_checks = 0;
    repeat (100000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    gi_in = 8'hFF;
    ta_in = 4'hF;
    tv_in = 3'h7;
    mi_in = 6'h3F;
    z1 = 8'h20;
    z2 = 8'h7B;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    rd({8'hE4}, 12);
    foreach (RSTV[i]) check("reset value", rb[i], RSTV[i]);
    check("reset gating", gi_o | {ta_o, tv_o, 1'b0} | {2'h0, mi_o}, 8'h00);
    check("zone 1a adj", z1_o, 8'h20);
    rd({8'h00}, 1);
    check("test reg", rb[0], 8'h00);
    wr({8'h00, 8'hFF});
    check("test mode", {7'h00, tte}, 8'h01);
    rd({8'h00}, 1);
    check("test reg", rb[0], 8'h01);
    wr({8'h00, 8'h00});
    check("test mode", {7'h00, tte}, 8'h00);
    wr({8'hF0, 8'h0A, 8'hE5, MSK[0], MSK[1], MSK[2], MSK[3], MSK[4], MSK[5], MSK[6], MSK[7], MSK[8]});
    rd({8'hFD}, 10);
    check("block length", rb[0], 8'h09);
    for (int i = 0; i < 9; i++) check("block byte", rb[i + 1], MSK[i]);
    for (int k = 0; k < 11; k++) begin
      rd({8'hF2 + 8'(k)}, 2);
      check("block length", rb[0], LENS[k]);
      check("block byte", rb[1], 8'h00);
    end
    for (int k = 0; k < 5; k++) begin
      wr({8'hE4, SL[k]});
      check("input err", gi_o, EG[k]);
      check("tach err", {4'h0, ta_o}, ET[k]);
      check("temp err", {5'h00, tv_o}, EV[k]);
      check("misc err", {2'h0, mi_o}, 8'h3A);
    end
    gi_in = 8'h0F;
    repeat (2) @(posedge clk);
    #1 check("input err", gi_o, 8'h0F);
    wr({8'hEE, 8'hF0, 8'h05});
    check("zone 1a adj", z1_o, 8'h10);
    check("zone 2a adj", z2_o, 8'h80);
    z1 = 8'h10;
    repeat (2) @(posedge clk);
    #1 check("zone 1a adj", z1_o, 8'h00);
    rd({8'hF1, 8'h02, 8'hE4, 8'h02}, 3);
    check("call length", rb[0], 8'h02);
    check("call byte", rb[1], 8'h00);
    check("call byte", rb[2], MSK[0]);
    wr({8'hFE, 8'h55});
    rd({8'hFE}, 1);
    check("reserved code", rb[0], 8'h00);
    wr({8'hF5, 8'h55, 8'h55});
    rd({8'hE5}, 1);
    check("mask kept", rb[0], MSK[0]);
    end_sim();
  end
endmodule : smbrg_top_tb
`default_nettype wire
